// ===== core/oscsw_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module oscsw_ctrl (
  input wire logic sys_clk_i, // 100 MHz clock
  input wire logic resetn_i, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [2:0] cfg_source_i, // nonvolatile source config
  input wire logic switch_monitor_cfg0_i, // freeze qualifier config
  input wire logic pll_locked_i, // pll reports lock
  input wire logic pll_timer_done_i, // pll start timer expired
  input wire logic osc_fail_i, // hardware oscillator failure
  output logic [2:0] clk_source_o, // active clock source
  output logic pin_map_freeze_o, // pin mapping frozen
  output logic osc_fail_trap_o, // oscillator failure trap
  output logic irq_o // level interrupt
);
  import oscsw_pkg::*;

  typedef enum logic [1:0] {OSCSW_IDLE, OSCSW_KEYED, OSCSW_OPEN} oscsw_key_e;

  function automatic logic is_pll_src(input logic [2:0] s);
    is_pll_src = (s == OSCSW_SRC_FAST_RC_PLL_SOURCE) || (s == OSCSW_SRC_PRIPLL);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic [2:0] cur_r;
  logic [2:0] req_r;
  logic freeze_r;
  logic pin_r;
  logic cf_r;
  logic go_r;
  logic cfg_loaded_r;
  oscsw_key_e key_r;
  logic [3:0] open_cnt_r;
  logic [OSCSW_EV_W-1:0] stat_r;
  logic [OSCSW_EV_W-1:0] mask_r;
  logic [31:0] rdata_r;

  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire hit_ctrl = (paddr == OSCSW_CTRL_OFS);
  wire hit_key = (paddr == OSCSW_KEY_OFS);
  wire hit_stat = (paddr == OSCSW_STAT_OFS);
  wire hit_mask = (paddr == OSCSW_MASK_OFS);
  wire mapped = hit_ctrl || hit_key || hit_stat || hit_mask;
  wire wr_ctrl = wr && hit_ctrl;
  wire wr_key = wr && hit_key;
  wire [15:0] wd = pwdata[15:0];

  ////////////////////////////////////////////////////////////////////////////
  // unlock sequence: key1 then key2, then one control write in a short window
  wire unlocked = (key_r == OSCSW_OPEN);
  wire ctrl_ok = wr_ctrl && unlocked;
  wire frozen = freeze_r && switch_monitor_cfg0_i;
  wire pll_status = pll_locked_i || pll_timer_done_i;

  // switch request allowed only when not frozen and not between pll modes
  wire [2:0] new_req = wd[OSCSW_REQ_LSB +: 3];
  wire bad_hop = is_pll_src(cur_r) && is_pll_src(new_req)
               && (cur_r != new_req);
  wire go_req = ctrl_ok && !frozen && wd[OSCSW_GO_BIT] && !go_r;
  wire go_ok = go_req && !bad_hop && (new_req != OSCSW_SRC_RSVD);
  wire reject = (wr_ctrl && !unlocked) || (go_req && !go_ok);

  logic sw_busy;
  logic sw_done;
  oscsw_cnt #(.W(8)) u_cnt (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .load_i(go_ok),
    .val_i(8'(OSCSW_SWITCH_CYC)),
    .busy_o(sw_busy),
    .done_o(sw_done)
  );

  wire cf_set = osc_fail_i || (ctrl_ok && wd[OSCSW_CF_BIT]);
  wire cf_clr = ctrl_ok && !wd[OSCSW_CF_BIT];
  wire [OSCSW_EV_W-1:0] ev = {reject, cf_set, sw_done};

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      key_r <= OSCSW_IDLE;
      open_cnt_r <= 4'h0;
    end else if (ctrl_ok) begin
      key_r <= OSCSW_IDLE;
    end else if (wr_key && wd == OSCSW_KEY1) begin
      key_r <= OSCSW_KEYED;
    end else if (wr_key && wd == OSCSW_KEY2 && key_r == OSCSW_KEYED) begin
      key_r <= OSCSW_OPEN;
      open_cnt_r <= 4'(OSCSW_UNLOCK_CYC);
    end else if (wr) begin
      key_r <= OSCSW_IDLE;
    end else if (key_r == OSCSW_OPEN) begin
      if (open_cnt_r == 4'h0) begin
        key_r <= OSCSW_IDLE;
      end
      open_cnt_r <= open_cnt_r - 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register fields
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cur_r <= OSCSW_SRC_FRC;
      req_r <= OSCSW_SRC_FRC;
      freeze_r <= 1'b0;
      pin_r <= 1'b0;
      go_r <= 1'b0;
      cfg_loaded_r <= 1'b0;
    end else begin
      // config bits are sampled on the first edge after release
      if (!cfg_loaded_r) begin
        req_r <= cfg_source_i;
        cfg_loaded_r <= 1'b1;
      end else if (ctrl_ok && !frozen && !sw_busy) begin
        req_r <= new_req;
      end
      if (ctrl_ok && !frozen) begin
        freeze_r <= wd[OSCSW_FRZ_BIT];
      end
      if (ctrl_ok) begin
        pin_r <= wd[OSCSW_PIN_BIT];
      end
      if (go_ok) begin
        go_r <= 1'b1;
      end else if (sw_done) begin
        go_r <= 1'b0;
        cur_r <= req_r;
      end
    end
  end

  // set wins over clear
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cf_r <= 1'b0;
    end else if (cf_set) begin
      cf_r <= 1'b1;
    end else if (cf_clr) begin
      cf_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, write one to clear, new events win
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stat_r <= '0;
      mask_r <= '0;
    end else begin
      stat_r <= ev | (stat_r & ~((wr && hit_stat) ? pwdata[OSCSW_EV_W-1:0]
                                                   : {OSCSW_EV_W{1'b0}}));
      if (wr && hit_mask) begin
        mask_r <= pwdata[OSCSW_EV_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path
  wire [15:0] ctrl_rd = {1'b0, cur_r, 1'b0, req_r, freeze_r, pin_r,
                         pll_status, 1'b0, cf_r, 2'b00, go_r};
  wire [31:0] rd_mux = hit_ctrl ? {16'h0000, ctrl_rd}
                     : hit_stat ? {29'h0, stat_r}
                     : hit_mask ? {29'h0, mask_r}
                     : 32'h0000_0000;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      rdata_r <= rd_mux;
    end
  end

  assign prdata = rd ? rdata_r : 32'h0000_0000;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign clk_source_o = cur_r;
  assign pin_map_freeze_o = pin_r;
  assign osc_fail_trap_o = cf_r;
  assign irq_o = |(stat_r & mask_r);
endmodule // oscsw_ctrl
`default_nettype wire

// ===== core/oscsw_pkg.sv
// Operation
// - bits 14..12 show the source now driving the clock, read only
// - bits 10..8 hold the source software requests, same encoding
// - codes: 0 fast rc, 1 rc pll, 2 primary, 3 primary pll, 4 reserved
// - with bit 7 set and monitor cfg0 set, clock and pll settings frozen
// - bit 6 is a writable pin mapping freeze flag
// - bit 5 reads one when pll locked or start timer expired
// - writes accepted only directly after the unlock key sequence
// - no direct switch between the two pll sources, go via fast rc
// - software writing one to clock fail acts as real failure, trap
// - bits 15 and 11 and other unused bits read zero, ignore writes
// - reset: requested source loads config bits, all else clears
`default_nettype none
package oscsw_pkg;
  localparam logic [11:0] OSCSW_CTRL_OFS = 12'h000;
  localparam logic [11:0] OSCSW_KEY_OFS = 12'h004;
  localparam logic [11:0] OSCSW_STAT_OFS = 12'h008;
  localparam logic [11:0] OSCSW_MASK_OFS = 12'h00c;
  localparam logic [15:0] OSCSW_KEY1 = 16'h0046;
  localparam logic [15:0] OSCSW_KEY2 = 16'h0057;
  localparam int OSCSW_CUR_LSB = 12;
  localparam int OSCSW_REQ_LSB = 8;
  localparam int OSCSW_FRZ_BIT = 7;
  localparam int OSCSW_PIN_BIT = 6;
  localparam int OSCSW_LOCK_BIT = 5;
  localparam int OSCSW_CF_BIT = 3;
  localparam int OSCSW_GO_BIT = 0;
  localparam logic [2:0] OSCSW_SRC_FRC = 3'h0;
  localparam logic [2:0] OSCSW_SRC_FAST_RC_PLL_SOURCE = 3'h1;
  localparam logic [2:0] OSCSW_SRC_PRI = 3'h2;
  localparam logic [2:0] OSCSW_SRC_PRIPLL = 3'h3;
  localparam logic [2:0] OSCSW_SRC_RSVD = 3'h4;
  localparam logic [2:0] OSCSW_SRC_LOW_POWER_RC_SOURCE = 3'h5;
  localparam logic [2:0] OSCSW_SRC_FRC16 = 3'h6;
  localparam logic [2:0] OSCSW_SRC_FRCN = 3'h7;
  // switch settle time in ns and derived cycles at 100 MHz
  localparam int OSCSW_CLK_MHZ = 100;
  localparam int OSCSW_SWITCH_NS = 200;
  localparam int OSCSW_SWITCH_CYC = (OSCSW_SWITCH_NS * OSCSW_CLK_MHZ) / 1000;
  // count loaded by the second key; the unlock then stays open for this many cycles plus one
  localparam int OSCSW_UNLOCK_CYC = 8;
  // interrupt status bits
  localparam int OSCSW_EV_DONE = 0;
  localparam int OSCSW_EV_FAIL = 1;
  localparam int OSCSW_EV_REJ = 2;
  localparam int OSCSW_EV_W = 3;
endpackage
`default_nettype wire

// ===== core/oscsw_cnt.sv
`timescale 1ns/1ps
`default_nettype none
// down counter giving a one-cycle done pulse after a load
module oscsw_cnt #(
  parameter int W = 8
) (
  input wire logic sys_clk_i, // clock
  input wire logic resetn_i, // async reset, low
  input wire logic load_i, // start count
  input wire logic [W-1:0] val_i, // cycles to wait
  output logic busy_o, // counting
  output logic done_o // one-cycle pulse at end
);
  logic [W-1:0] cnt_r;
  logic busy_r;
  logic done_r;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (load_i) begin
        cnt_r <= val_i;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (cnt_r <= W'(1)) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
        cnt_r <= cnt_r - W'(1);
      end
    end
  end
  assign busy_o = busy_r;
  assign done_o = done_r;
endmodule // oscsw_cnt
`default_nettype wire

// ===== verification/oscsw_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module oscsw_ctrl_checker (
  input wire logic sys_clk_i, // clock
  input wire logic resetn_i, // reset, low
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic pwrite, // apb
  input wire logic [11:0] paddr, // apb
  input wire logic [31:0] pwdata, // apb
  input wire logic [31:0] prdata, // apb
  input wire logic pready, // apb
  input wire logic pslverr, // apb
  input wire logic [2:0] cfg_source_i, // config
  input wire logic switch_monitor_cfg0_i, // config
  input wire logic pll_locked_i, // pll
  input wire logic pll_timer_done_i, // pll
  input wire logic osc_fail_i, // failure
  input wire logic [2:0] clk_source_o, // source
  input wire logic pin_map_freeze_o, // freeze
  input wire logic osc_fail_trap_o, // trap
  input wire logic irq_o // irq
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  wire logic rd_ctrl = psel && penable && !pwrite && paddr == 12'h000;
  // read data is captured in the setup cycle, so compare with that cycle
  property p_cur; rd_ctrl |-> prdata[14:12] == $past(clk_source_o); endproperty
  a_cur: assert property (p_cur) else $error("current field");
  property p_zero;
    rd_ctrl |-> prdata[31:15] == 17'h0 && !prdata[11] && !prdata[4];
  endproperty
  a_zero: assert property (p_zero) else $error("unused bits");
  property p_pin; rd_ctrl |-> prdata[6] == $past(pin_map_freeze_o); endproperty
  a_pin: assert property (p_pin) else $error("pin freeze bit");
  property p_lock;
    rd_ctrl |-> prdata[5] == $past(pll_locked_i || pll_timer_done_i);
  endproperty
  a_lock: assert property (p_lock) else $error("pll status");
  property p_fail; osc_fail_i |=> osc_fail_trap_o; endproperty
  a_fail: assert property (p_fail) else $error("no trap");
  property p_pll;
    $changed(clk_source_o) |-> !($past(clk_source_o) == 3'h1 &&
      clk_source_o == 3'h3) && !($past(clk_source_o) == 3'h3 &&
      clk_source_o == 3'h1);
  endproperty
  a_pll: assert property (p_pll) else $error("pll to pll");
  property p_rsvd; clk_source_o != 3'h4; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved source");
  property p_err; psel && penable && paddr > 12'h00c |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no slave error");
  property p_rst;
    disable iff (1'b0) !resetn_i ##1 !resetn_i |-> clk_source_o == 3'h0 &&
      !pin_map_freeze_o && !osc_fail_trap_o && !irq_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset outputs");
  c_sw: cover property ($changed(clk_source_o));
  c_err: cover property (pslverr);
  c_irq: cover property ($rose(irq_o));
endmodule // oscsw_ctrl_checker
`default_nettype wire

// ===== verification/oscillator_switch_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module oscillator_switch_control_test;
  import oscsw_pkg::*;
  logic sys_clk_i = 0;
  logic resetn_i = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err, pin_map_freeze_o, osc_fail_trap_o, irq_o;
  logic [2:0] cfg_source_i = 3'h2;
  logic [2:0] clk_source_o;
  logic switch_monitor_cfg0_i = 0;
  logic pll_locked_i = 0;
  logic pll_timer_done_i = 0;
  logic osc_fail_i = 0;
  int mismatches = 0;
  int n_tests = 0;
  oscsw_ctrl i_dut (.*);
  always #5 sys_clk_i = ~sys_clk_i;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk_i);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge sys_clk_i);
    penable <= 1'b1;
    do @(posedge sys_clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // the key pair must come right before the control write or it relocks
  task automatic cw(input logic [15:0] d);
    apb(1'b1, 12'h004, {16'h0, OSCSW_KEY1});
    apb(1'b1, 12'h004, {16'h0, OSCSW_KEY2});
    apb(1'b1, 12'h000, {16'h0, d});
  endtask
  task automatic sw(input logic [2:0] s);
    cw({5'h0, s, 8'h01});
    repeat (25) @(posedge sys_clk_i);
  endtask
  task automatic cur(input logic [2:0] e);
    chk({29'h0, clk_source_o}, {29'h0, e});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_codes;
    for (int c = 0; c < 8; c++) begin
      sw(3'(c));
      cur((c == 4) ? 3'h3 : 3'(c));
    end
  endtask
  task automatic t_pll;
    sw(3'h3);
    sw(3'h1);
    cur(3'h3);
    sw(3'h0);
    sw(3'h1);
    cur(3'h1);
  endtask
  task automatic t_unlock;
    apb(1'b1, 12'h000, 32'h0541);
    repeat (25) @(posedge sys_clk_i);
    cur(3'h1);
    rchk(12'h008, 32'h5);
    apb(1'b1, 12'h008, 32'h7);
    cw(16'hf840);
    rchk(12'h000, 32'h1040);
    chk(pin_map_freeze_o, 1);
  endtask
  task automatic t_freeze;
    switch_monitor_cfg0_i <= 1'b1;
    cw(16'h00c0);
    sw(3'h2);
    cur(3'h1);
    switch_monitor_cfg0_i <= 1'b0;
    sw(3'h2);
    cur(3'h2);
  endtask
  task automatic t_fail;
    apb(1'b1, 12'h008, 32'h7);
    cw(16'h0208);
    // flops written at the access edge settle only after that time step
    @(posedge sys_clk_i);
    chk(osc_fail_trap_o, 1);
    rchk(12'h008, 32'h2);
    apb(1'b1, 12'h00c, 32'h0);
    @(posedge sys_clk_i);
    chk(irq_o, 0);
    apb(1'b1, 12'h00c, 32'h7);
    @(posedge sys_clk_i);
    chk(irq_o, 1);
    cw(16'h0200);
    apb(1'b1, 12'h008, 32'h7);
    @(posedge sys_clk_i);
    chk({irq_o, osc_fail_trap_o}, 0);
    osc_fail_i <= 1'b1;
    @(posedge sys_clk_i);
    osc_fail_i <= 1'b0;
    @(posedge sys_clk_i);
    chk(osc_fail_trap_o, 1);
  endtask
  task automatic t_misc;
    pll_timer_done_i <= 1'b1;
    rchk(12'h000, 32'h2228);
    apb(1'b0, 12'h010, 32'h0);
    chk(err, 1);
  endtask
  task automatic end_sim;
    if (mismatches == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    mismatches++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rchk(12'h000, 32'h0200);
    t_codes();
    t_pll();
    t_unlock();
    t_freeze();
    t_fail();
    t_misc();
    end_sim();
  end
endmodule // oscillator_switch_control_test
bind oscsw_ctrl oscsw_ctrl_checker i_chk (.*);
`default_nettype wire
